/* rtl/accel_defs.vh */
`ifndef ACCEL_DEFS_VH
`define ACCEL_DEFS_VH

// Fixed upper six bits of the bus target identifier
`define ID_FIXED 6'h0C

// Receive byte kinds
`define KIND_ADDR 2'h0
`define KIND_PTR 2'h1
`define KIND_DATA 2'h2

// Register pointers of the read-only axis bytes (high then low per axis)
`define AXIS_BYTES 8'h06

// Control byte that carries the range-select code in bits 1:0
`define RANGE_REG 4'hA
`define RANGE_HIGH_BIT 1
`define RANGE_LOW_BIT 0
`define RANGE_RST 8'h03

// Range-select codes
`define RANGE_2G 2'h3
`define RANGE_4G 2'h2
`define RANGE_6G 2'h1
`define RANGE_8G 2'h0

// Counts per g in each range, and the mid-scale code
`define SENS_2G 10'h333
`define SENS_4G 10'h19A
`define SENS_6G 10'h111
`define SENS_8G 10'h0CD
`define CODE_MID 12'h800
`define CODE_MAX 12'hFFF

// Acceleration input scaling: one g is two to this power
`define G_SHIFT 10

`endif

/* rtl/accel_code_enc.v */
`timescale 1ns/10ps
`default_nettype none
`include "accel_defs.vh"

module accel_code_enc #(
  parameter ACC_W = 16
) (
  input wire signed [ACC_W-1:0] accel,
  input wire [1:0] range_sel,
  output reg [11:0] code
);

  reg [9:0] sens;
  wire signed [ACC_W+10:0] prod;
  wire signed [ACC_W+10:0] scaled;
  wire signed [ACC_W+10:0] sum;

  // Counts per g for each range code
  always @* begin
    case (range_sel)
      `RANGE_2G: sens = `SENS_2G;
      `RANGE_4G: sens = `SENS_4G;
      `RANGE_6G: sens = `SENS_6G;
      default: sens = `SENS_8G;
    endcase
  end

  // Zero acceleration lands on mid-scale in every range
  assign prod = accel * $signed({1'b0, sens});
  assign scaled = prod >>> `G_SHIFT;
  assign sum = scaled + $signed({1'b0, `CODE_MID});

  // Saturate rather than wrap at the ends of the scale
  always @* begin
    if (sum < 0) begin
      code = 12'h000;
    end else if (sum > $signed({1'b0, `CODE_MAX})) begin
      code = `CODE_MAX;
    end else begin
      code = sum[11:0];
    end
  end

endmodule

`default_nettype wire

/* rtl/accel_i2c_slave.v */
`timescale 1ns/10ps
`default_nettype none
`include "accel_defs.vh"

module accel_i2c_slave #(
  parameter ADDR_W = 4,
  parameter ACC_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire scl_in,
  input wire sda_in,
  input wire addr_sel,
  input wire [ACC_W-1:0] accel_x,
  input wire [ACC_W-1:0] accel_y,
  input wire [ACC_W-1:0] accel_z,
  output wire sda_out,
  output wire sda_oe,
  output wire scl_out,
  output wire scl_oe,
  output wire bus_busy,
  output wire dev_addressed,
  output wire wr_stb,
  output wire [7:0] wr_ptr,
  output wire [7:0] wr_data,
  output wire [11:0] x_code,
  output wire [11:0] y_code,
  output wire [11:0] z_code,
  output wire range_select_high,
  output wire range_select_low
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RX = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_TX = 3'h3;
  localparam ST_RACK = 3'h4;
  localparam ST_IGNORE = 3'h5;
  localparam DEPTH = 1 << ADDR_W;

  reg scl_s1_q, scl_s2_q, scl_s3_q;
  reg sda_s1_q, sda_s2_q, sda_s3_q;
  reg adr_s1_q, adr_s2_q;
  reg id_bit_q;
  reg [2:0] state_q;
  reg [1:0] kind_q;
  reg [2:0] cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] ptr_q;
  reg rw_q;
  reg drv_q;
  reg mack_q;
  reg sda_oe_q;
  reg sda_out_q;
  reg scl_oe_q;
  reg scl_out_q;
  reg busy_q;
  reg addressed_q;
  reg wr_stb_q;
  reg [7:0] wr_ptr_q;
  reg [7:0] wr_data_q;
  reg [7:0] mem [0:DEPTH-1];
  wire [35:0] codes;
  wire [3*ACC_W-1:0] acc_all;
  wire [7:0] byte_in;
  wire [7:0] rd_now;
  wire scl_rise, scl_fall, start_c, stop_c;
  integer i;

  // Edges are judged only between the second and third stages
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign start_c = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_c = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign byte_in = {shift_q[6:0], sda_s2_q};
  assign acc_all = {accel_z, accel_y, accel_x};

  // Read source: axis bytes first, then the stored bytes
  function [7:0] rd_byte;
    input [7:0] p;
    reg [11:0] c;
    begin
      c = codes[12 * p[2:1] +: 12];
      if (p < `AXIS_BYTES) begin
        rd_byte = p[0] ? {c[3:0], 4'h0} : c[11:4];
      end else begin
        rd_byte = mem[p[ADDR_W-1:0]];
      end
    end
  endfunction

  assign rd_now = rd_byte(ptr_q);

  // Pin synchronisers; the strap is caught only while the bus is free
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      adr_s1_q <= 1'b0;
      adr_s2_q <= 1'b0;
      id_bit_q <= 1'b0;
    end else if (clk_en) begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      adr_s1_q <= addr_sel;
      adr_s2_q <= adr_s1_q;
      if (!busy_q) begin
        id_bit_q <= adr_s2_q;
      end
    end
  end

  // Axis code encoders, one per axis, outputs registered
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      wire [11:0] enc;
      reg [11:0] cq;
      accel_code_enc #(.ACC_W(ACC_W)) u_enc (
        .accel(acc_all[g*ACC_W +: ACC_W]),
        .range_sel({mem[`RANGE_REG][`RANGE_HIGH_BIT],
                    mem[`RANGE_REG][`RANGE_LOW_BIT]}),
        .code(enc)
      );
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cq <= `CODE_MID;
        end else if (clk_en) begin
          cq <= enc;
        end
      end
      assign codes[12*g +: 12] = cq;
    end
  endgenerate

  // Protocol engine; start and stop outrank clock edges
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      kind_q <= `KIND_ADDR;
      cnt_q <= 3'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      drv_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
      scl_oe_q <= 1'b0;
      scl_out_q <= 1'b0;
      busy_q <= 1'b0;
      addressed_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_ptr_q <= 8'h00;
      wr_data_q <= 8'h00;
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= 8'h00;
      end
      mem[`RANGE_REG] <= `RANGE_RST;
    end else if (clk_en) begin
      wr_stb_q <= 1'b0;
      // SCL is never driven: no stretching, no clock of our own
      scl_oe_q <= 1'b0;
      if (start_c) begin
        // Also a repeated start: a fresh address byte follows
        busy_q <= 1'b1;
        state_q <= ST_RX;
        kind_q <= `KIND_ADDR;
        cnt_q <= 3'h0;
        drv_q <= 1'b0;
        sda_oe_q <= 1'b0;
        addressed_q <= 1'b0;
      end else if (stop_c) begin
        busy_q <= 1'b0;
        state_q <= ST_IDLE;
        drv_q <= 1'b0;
        sda_oe_q <= 1'b0;
        addressed_q <= 1'b0;
      end else begin
        case (state_q)
          ST_RX: begin
            if (scl_rise) begin
              shift_q <= byte_in;
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                state_q <= ST_ACK;
                if (kind_q == `KIND_ADDR) begin
                  // Compare upper seven bits with our identifier
                  if (byte_in[7:1] != {`ID_FIXED, id_bit_q}) begin
                    state_q <= ST_IGNORE;
                  end else begin
                    addressed_q <= 1'b1;
                    rw_q <= byte_in[0];
                  end
                end else if (kind_q == `KIND_PTR) begin
                  // MSB is taken as sent; the master keeps it zero
                  ptr_q <= byte_in;
                end else begin
                  mem[ptr_q[ADDR_W-1:0]] <= byte_in;
                  wr_stb_q <= 1'b1;
                  wr_ptr_q <= ptr_q;
                  wr_data_q <= byte_in;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall && !drv_q) begin
              drv_q <= 1'b1;
              sda_oe_q <= 1'b1;
            end else if (scl_fall) begin
              drv_q <= 1'b0;
              cnt_q <= 3'h0;
              if (kind_q == `KIND_ADDR && rw_q) begin
                // First read bit goes out on the fall ending the ack
                state_q <= ST_TX;
                tx_q <= rd_now;
                sda_oe_q <= ~rd_now[7];
              end else begin
                state_q <= ST_RX;
                sda_oe_q <= 1'b0;
                if (kind_q == `KIND_ADDR) begin
                  kind_q <= `KIND_PTR;
                end else if (kind_q == `KIND_PTR) begin
                  kind_q <= `KIND_DATA;
                end else begin
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                // Release so the master can answer
                sda_oe_q <= 1'b0;
                state_q <= ST_RACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                sda_oe_q <= ~tx_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s2_q;
              if (!sda_s2_q) begin
                ptr_q <= ptr_q + 8'h01;
              end
            end else if (scl_fall) begin
              cnt_q <= 3'h0;
              if (mack_q) begin
                state_q <= ST_TX;
                tx_q <= rd_now;
                sda_oe_q <= ~rd_now[7];
              end else begin
                // Not acknowledged: wait for stop or restart
                state_q <= ST_IGNORE;
              end
            end
          end
          ST_IGNORE: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain pins: data level is always low, enable does the work
  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign scl_out = scl_out_q;
  assign scl_oe = scl_oe_q;
  assign bus_busy = busy_q;
  assign dev_addressed = addressed_q;
  assign wr_stb = wr_stb_q;
  assign wr_ptr = wr_ptr_q;
  assign wr_data = wr_data_q;
  assign x_code = codes[11:0];
  assign y_code = codes[23:12];
  assign z_code = codes[35:24];
  assign range_select_high = mem[`RANGE_REG][`RANGE_HIGH_BIT];
  assign range_select_low = mem[`RANGE_REG][`RANGE_LOW_BIT];

endmodule

`default_nettype wire

/* bench/accel_i2c_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module accel_i2c_monitor #(
  parameter ADDR_W = 4,
  parameter ACC_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  input wire [ACC_W-1:0] accel_x,
  input wire sda_out,
  input wire sda_oe,
  input wire scl_oe,
  input wire bus_busy,
  input wire dev_addressed,
  input wire wr_stb,
  input wire [7:0] wr_ptr,
  input wire [7:0] wr_data,
  input wire [11:0] x_code,
  input wire range_select_high,
  input wire range_select_low
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg seen_q;
  reg [7:0] last_q;

  // Last stored pointer, forgotten once the bus is free
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
      last_q <= 8'h00;
    end else if (!bus_busy) begin
      seen_q <= 1'b0;
    end else if (wr_stb) begin
      seen_q <= 1'b1;
      last_q <= wr_ptr;
    end
  end

  AST_NO_CLOCK: assert property (scl_oe == 1'b0)
    else $error("slave drove the clock line");
  AST_ACK_LOW: assert property (sda_oe |-> !sda_out && dev_addressed)
    else $error("data line pulled while not addressed");
  AST_IDLE_QUIET: assert property (!bus_busy |-> !sda_oe)
    else $error("data line pulled on a free bus");
  AST_START_BUSY: assert property ($fell(sda_in) && scl_in && $past(scl_in)
    |-> ##[1:4] bus_busy) else $error("start not seen");
  AST_STOP_FREE: assert property ($rose(sda_in) && scl_in && $past(scl_in)
    |-> ##[1:4] (!bus_busy && !dev_addressed)) else $error("stop not seen");
  AST_STB_ONE: assert property (wr_stb |=> !wr_stb)
    else $error("store strobe longer than one cycle");
  AST_STB_ADDRESSED: assert property (wr_stb |-> bus_busy && dev_addressed)
    else $error("store without a matched frame");
  AST_PTR_STEP: assert property (wr_stb && seen_q |-> wr_ptr == last_q + 8'h01)
    else $error("pointer did not advance by one");
  AST_RANGE_TAKE: assert property (wr_stb && wr_ptr == 8'h0A
    |=> {range_select_high, range_select_low} == wr_data[1:0])
    else $error("range code not taken");
  // Range bits and the strobe are loaded at the same edge
  AST_RANGE_HOLD: assert property
    (!$stable({range_select_high, range_select_low}) |-> wr_stb)
    else $error("range code changed without a store");
  AST_ZERO_MID: assert property ((accel_x == {ACC_W{1'b0}})[*3]
    |=> x_code == 12'h800) else $error("zero input not mid-scale");
endmodule

bind accel_i2c_slave accel_i2c_monitor #(.ADDR_W(ADDR_W), .ACC_W(ACC_W)) u_mon (
  .clk, .sys_rst, .scl_in, .sda_in, .accel_x, .sda_out, .sda_oe, .scl_oe,
  .bus_busy, .dev_addressed, .wr_stb, .wr_ptr, .wr_data, .x_code,
  .range_select_high, .range_select_low);
`default_nettype wire

/* bench/i2c_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  output logic scl_drv,
  output logic sda_drv,
  input wire scl_w,
  input wire sda_w
);
  // Both lines released while idle; the clock stands still between frames
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // Data set mid-low, sampled mid-high
  task automatic bitx(input logic v, output logic s);
    #16 sda_drv = v;
    #16 scl_drv = 1'b1;
    wait (scl_w);
    #16 s = sda_w;
    #16 scl_drv = 1'b0;
  endtask

  // Called on a clock edge or 3 ns after one, so bus edges never meet
  // a clock edge; the long first wait lets a slave end its acknowledge
  // before a repeated start raises the clock
  task automatic start();
    #19 sda_drv = 1'b1;
    #16 scl_drv = 1'b1;
    #16 sda_drv = 1'b0;
    #16 scl_drv = 1'b0;
  endtask

  task automatic stop();
    #16 sda_drv = 1'b0;
    #16 scl_drv = 1'b1;
    #16 sda_drv = 1'b1;
    #16;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      b[i] = s;
    end
    bitx(last, s);
  endtask
endmodule
`default_nettype wire

/* bench/accel_i2c_register_write_slave_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module accel_i2c_register_write_slave_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic addr_sel = 1'b0;
  logic [15:0] accel_x = 16'h0000;
  logic [15:0] accel_y = 16'h0000;
  logic [15:0] accel_z = 16'h0000;
  wire sda_out, sda_oe, scl_out, scl_oe, bus_busy, dev_addressed, wr_stb;
  wire range_select_high, range_select_low, scl_drv, sda_drv;
  wire [7:0] wr_ptr, wr_data;
  wire [11:0] x_code, y_code, z_code;
  // Open-drain lines with pull-ups
  wire scl_w = scl_drv & ~(scl_oe & ~scl_out);
  wire sda_w = sda_drv & ~(sda_oe & ~sda_out);
  int fail_count = 0;
  int checks_done = 0;
  int pg[4] = '{2253, 2321, 2458, 2867};
  logic [7:0] wq[$], eq[$], sp[$], sd[$];
  logic [11:0] cx, cy, cz;

  initial begin
    forever #4 clk = ~clk;
  end

  accel_i2c_slave dut (.clk, .sys_rst, .clk_en, .scl_in(scl_w),
    .sda_in(sda_w), .addr_sel, .accel_x, .accel_y, .accel_z, .sda_out,
    .sda_oe, .scl_out, .scl_oe, .bus_busy, .dev_addressed, .wr_stb,
    .wr_ptr, .wr_data, .x_code, .y_code, .z_code, .range_select_high,
    .range_select_low);
  i2c_master_model m (.scl_drv, .sda_drv, .scl_w, .sda_w);

  // Every stored byte, in order
  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      sp.push_back(wr_ptr);
      sd.push_back(wr_data);
    end
  end

  task automatic chk_code(input string n, input logic [11:0] e,
      input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_code(n, {11'h000, e}, {11'h000, g});
  endtask

  // Mid-scale plus floor of input times counts per g over 1024
  function automatic logic [11:0] exp_code(input logic [1:0] r,
      input logic signed [15:0] a);
    int v;
    v = 2048 + ((a * (pg[r] - 2048)) >>> 10);
    return v < 0 ? 12'h000 : v > 4095 ? 12'hFFF : 12'(v);
  endfunction

  task automatic xfer(input logic [6:0] id, input logic [7:0] p,
      input logic ea);
    logic a;
    sp.delete();
    sd.delete();
    m.start();
    repeat (4) @(posedge clk);
    chk_bit("busy", 1'b1, bus_busy);
    // Step off the clock edge before the bus moves again
    #3;
    m.wbyte({id, 1'b0}, a);
    chk_bit("addr ack", ea, a);
    m.wbyte(p, a);
    chk_bit("ptr ack", ea, a);
    for (int i = 0; i < wq.size(); i++) begin
      m.wbyte(wq[i], a);
      chk_bit("data ack", ea, a);
    end
    m.stop();
    repeat (4) @(posedge clk);
    chk_bit("free", 1'b0, bus_busy);
    chk_code("stores", ea ? 12'(wq.size()) : 12'h000, 12'(sp.size()));
    for (int i = 0; i < sp.size(); i++) begin
      chk_code("wr ptr", {4'h0, p + 8'(i)}, {4'h0, sp[i]});
      chk_code("wr data", {4'h0, wq[i]}, {4'h0, sd[i]});
    end
  endtask

  // Pointer write, repeated start, then read with ack on all but the last
  task automatic rd(input logic [6:0] id, input logic [7:0] p);
    logic a;
    logic [7:0] b;
    m.start();
    m.wbyte({id, 1'b0}, a);
    m.wbyte(p, a);
    m.start();
    m.wbyte({id, 1'b1}, a);
    chk_bit("rd ack", 1'b1, a);
    for (int i = 0; i < eq.size(); i++) begin
      m.rbyte(i == eq.size() - 1, b);
      chk_code("rd byte", {4'h0, eq[i]}, {4'h0, b});
    end
    m.stop();
    repeat (4) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, far beyond the roughly 40 us the sequence needs
  initial begin
    #300000;
    fail_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h01EA));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_code("x reset", 12'h800, x_code);
    chk_bit("busy reset", 1'b0, bus_busy);
    chk_bit("range reset", 1'b1, range_select_high);
    // Enable low: the code must hold although the input moves
    clk_en <= 1'b0;
    accel_x <= 16'h0400;
    repeat (4) @(posedge clk);
    chk_code("x frozen", 12'h800, x_code);
    clk_en <= 1'b1;
    accel_x <= 16'h0000;
    repeat (4) @(posedge clk);
    for (int r = 3; r >= 0; r--) begin
      wq = '{8'(r)};
      xfer(7'h18, 8'h0A, 1'b1);
      chk_bit("range high", r[1], range_select_high);
      chk_bit("range low", r[0], range_select_low);
      accel_x <= 16'h0400;
      accel_y <= 16'hFC00;
      accel_z <= 16'h0000;
      repeat (4) @(posedge clk);
      chk_code("x one g", 12'(pg[r]), x_code);
      chk_code("y minus g", 12'(4096 - pg[r]), y_code);
      chk_code("z zero", 12'h800, z_code);
      accel_x <= 16'($urandom);
      accel_y <= 16'($urandom);
      accel_z <= 16'($urandom % 2048);
      repeat (4) @(posedge clk);
      cx = exp_code(2'(r), accel_x);
      cy = exp_code(2'(r), accel_y);
      cz = exp_code(2'(r), accel_z);
      chk_code("x rand", cx, x_code);
      chk_code("y rand", cy, y_code);
      chk_code("z rand", cz, z_code);
      eq = '{cx[11:4], {cx[3:0], 4'h0}, cy[11:4], {cy[3:0], 4'h0},
        cz[11:4], {cz[3:0], 4'h0}};
      rd(7'h18, 8'h00);
    end
    // Strap high: the old identifier is ignored, the new one answers
    addr_sel <= 1'b1;
    repeat (4) @(posedge clk);
    wq = '{8'($urandom)};
    xfer(7'h18, 8'h07, 1'b0);
    wq = '{8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
    xfer(7'h19, 8'h0D, 1'b1);
    eq = wq;
    rd(7'h19, 8'h0D);
    print_verdict();
  end
endmodule
`default_nettype wire
